// >>> twm_defines.svh
// Purpose: constants for the two-wire master-transmitter block
// Assumes: included once per compile unit through its guard
// Notes: register indices are plain port addresses
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH
// ****************************************
// Register addresses
// ****************************************
`define TWM_ADDR_CTRL 2'h0
`define TWM_ADDR_STATE 2'h1
`define TWM_ADDR_BUF 2'h2
`define TWM_ADDR_BITRATE 2'h3
// ****************************************
// Control bit positions
// ****************************************
`define TWM_B_DONE 7
`define TWM_B_ACKEN 6
`define TWM_B_START 5
`define TWM_B_STOP 4
`define TWM_B_WCOL 3
`define TWM_B_EN 2
`define TWM_B_IRQEN 0
// ****************************************
// State codes
// ****************************************
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_D_ACK 8'h28
`define TWM_ST_D_NACK 8'h30
`define TWM_ST_ARB 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_SL_W 8'h68
`define TWM_ST_SL_G 8'h78
`define TWM_ST_SL_R 8'hB0
`define TWM_ST_IDLE 8'hF8
// ****************************************
// Reset values, timing and own slave address
// ****************************************
`define TWM_BITRATE_RST 8'h0C
`define TWM_OWN_ADDR 7'h2A
`endif

// >>> twm_master.sv
// Purpose: two-wire master-transmitter with control, state and byte registers
// Assumes: single 100 MHz clock, bus pins sampled through two flip-flops
// Notes: master receive and slave modes only report hand-off state codes
// ****************************************
// What this block does
// - Works only when enabled; writing done clears it
// - START issued only when bus is free or already held by us
// - After START, set done, code 08
// - Address read bit selects receive, else send
// - State codes read with prescaler field zero
// - After address, done with 18, 20 or 38
// - Buffer write while done low: discard, collision
// - Repeated START reports 10, keeps bus
// - In 10, address sent; read bit switches mode
// - Address acked gives 18, else 20
// - Data acked gives 28, else 30
// - Clear sends byte, start restarts, stop stops
// - Start and stop: STOP then START, clear stop
// - Lost arbitration gives 38; release or restart
// - Addressed as slave after loss: 68 or B0
// - Transfer suspended while done is set
// ****************************************
`timescale 1ns/10ps
`include "twm_defines.svh"
module twm_master
  import twm_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // Register port
  input wire logic [1:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Bus pins, open drain: enable high pulls low
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SCL,
  output logic O_SCL_OE,
  output logic O_SDA,
  output logic O_SDA_OE,
  // Status
  output logic O_DONE
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic scl_m_q, scl_q, sda_m_q, sda_q, scl_p_q, sda_p_q;
  // Two stages before any logic looks at the pins
  always_ff @(posedge I_CLK)
  begin
    scl_m_q <= I_SCL;
    sda_m_q <= I_SDA;
    scl_q <= scl_m_q;
    sda_q <= sda_m_q;
    scl_p_q <= scl_q;
    sda_p_q <= sda_q;
  end

  // ****************************************
  // State declarations
  // ****************************************
  twm_state_t st_q, st_d;
  logic [7:0] ctrl_q, ctrl_d;      // Control bits
  logic [4:0] code_q, code_d;      // State code, upper five bits
  logic [7:0] buf_q, buf_d;        // Byte buffer, shifts out
  logic [7:0] rate_q, rate_d;      // Half-bit period in clocks, minus one
  logic [7:0] tmr_q, tmr_d;        // Half-bit timer
  logic [2:0] bit_q, bit_d;        // Bits left in byte, minus one
  logic addr_q, addr_d;            // Current byte is an address
  logic owner_q, owner_d;          // We hold the bus
  logic busy_q, busy_d;            // Bus held by any master, us included
  logic restart_q, restart_d;      // START follows the pending STOP
  logic sda_lo_q, sda_lo_d;        // Drive SDA low
  logic scl_lo_q, scl_lo_d;        // Drive SCL low
  logic [7:0] rdata_q, rdata_d;
  logic slv_hit_q, slv_hit_d;      // Own address seen after loss
  logic [7:0] shadow_q, shadow_d;  // Bits seen on the wire

  // Full state code byte; prescaler field always zero
  function automatic logic [7:0] code_byte(input logic [4:0] c);
    code_byte = {c, 3'h0};
  endfunction

  // Upper five bits of an eight-bit code
  function automatic logic [4:0] code_of(input logic [7:0] c);
    code_of = c[7:3];
  endfunction

  logic start_ev, stop_ev, tick;
  // Clock must be seen high on two samples, so a data edge next to a clock edge is no condition
  assign start_ev = scl_q && scl_p_q && sda_p_q && !sda_q;
  assign stop_ev = scl_q && scl_p_q && !sda_p_q && sda_q;
  assign tick = (tmr_q == 8'h00);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    st_d = st_q;
    ctrl_d = ctrl_q;
    code_d = code_q;
    buf_d = buf_q;
    rate_d = rate_q;
    tmr_d = tick ? rate_q : tmr_q - 8'h01;
    bit_d = bit_q;
    addr_d = addr_q;
    owner_d = owner_q;
    restart_d = restart_q;
    sda_lo_d = sda_lo_q;
    scl_lo_d = scl_lo_q;
    slv_hit_d = slv_hit_q;
    shadow_d = shadow_q;
    rdata_d = 8'h00;
    // Bus busy tracking from observed conditions
    busy_d = start_ev ? 1'b1 : (stop_ev ? 1'b0 : busy_q);
    // Register reads
    if (I_RD)
    begin
      if (I_ADDR == `TWM_ADDR_CTRL)
        rdata_d = ctrl_q;
      else if (I_ADDR == `TWM_ADDR_STATE)
        rdata_d = code_byte(code_q);
      else if (I_ADDR == `TWM_ADDR_BUF)
        rdata_d = buf_q;
      else
        rdata_d = rate_q;
    end
    // Register writes
    if (I_WR)
    begin
      if (I_ADDR == `TWM_ADDR_CTRL)
      begin
        ctrl_d[`TWM_B_ACKEN] = I_WDATA[`TWM_B_ACKEN];
        ctrl_d[`TWM_B_START] = I_WDATA[`TWM_B_START];
        ctrl_d[`TWM_B_STOP] = I_WDATA[`TWM_B_STOP];
        ctrl_d[`TWM_B_EN] = I_WDATA[`TWM_B_EN];
        ctrl_d[`TWM_B_IRQEN] = I_WDATA[`TWM_B_IRQEN];
        if (I_WDATA[`TWM_B_DONE])
          ctrl_d[`TWM_B_DONE] = 1'b0;
      end
      else if (I_ADDR == `TWM_ADDR_BUF)
      begin
        if (ctrl_q[`TWM_B_DONE])
        begin
          buf_d = I_WDATA;
          ctrl_d[`TWM_B_WCOL] = 1'b0;
        end
        else
          ctrl_d[`TWM_B_WCOL] = 1'b1;
      end
      else if (I_ADDR == `TWM_ADDR_BITRATE)
        rate_d = I_WDATA;
    end
    // Sequencer
    if (!ctrl_d[`TWM_B_EN])
    begin
      // Disabled: release everything
      st_d = TWM_IDLE;
      owner_d = 1'b0;
      sda_lo_d = 1'b0;
      scl_lo_d = 1'b0;
      code_d = code_of(`TWM_ST_IDLE);
    end
    else
    begin
      case (st_q)
        TWM_IDLE:
        begin
          // Done clear with start set: wait for a free bus
          if (!ctrl_q[`TWM_B_DONE] && ctrl_q[`TWM_B_START])
            st_d = TWM_WAIT_FREE;
        end
        TWM_WAIT_FREE:
        begin
          // Our own START marks the bus busy, so a restart while we own it may go ahead
          if ((!busy_q || owner_q) && scl_q && sda_q && tick)
          begin
            sda_lo_d = 1'b1;
            st_d = TWM_START_A;
          end
        end
        TWM_START_A:
        begin
          if (tick)
          begin
            scl_lo_d = 1'b1;
            st_d = TWM_START_B;
          end
        end
        TWM_START_B:
        begin
          // START done; report and hold clock low
          owner_d = 1'b1;
          code_d = owner_q ? code_of(`TWM_ST_RSTART) : code_of(`TWM_ST_START);
          ctrl_d[`TWM_B_DONE] = 1'b1;
          addr_d = 1'b1;
          st_d = TWM_HOLD;
        end
        TWM_HOLD:
        begin
          // Suspended until software clears done
          if (!ctrl_q[`TWM_B_DONE] && tick)
          begin
            if (ctrl_q[`TWM_B_STOP])
            begin
              restart_d = ctrl_q[`TWM_B_START];
              sda_lo_d = 1'b1;
              st_d = TWM_STOP_A;
            end
            else if (ctrl_q[`TWM_B_START])
            begin
              // Repeated START: raise SDA, then SCL
              sda_lo_d = 1'b0;
              st_d = TWM_STOP_C;
              restart_d = 1'b1;
            end
            else if (!owner_q)
            begin
              // After arbitration loss: release, unaddressed
              scl_lo_d = 1'b0;
              sda_lo_d = 1'b0;
              code_d = code_of(`TWM_ST_IDLE);
              st_d = TWM_IDLE;
            end
            else
            begin
              // Send the buffer
              sda_lo_d = !buf_q[7];
              bit_d = 3'h7;
              st_d = TWM_BIT_LOW;
            end
          end
        end
        TWM_BIT_LOW:
        begin
          // Data moves a clock after SCL falls, never with it: keeps hold time on the wire
          if (owner_q)
            sda_lo_d = !buf_q[7];
          if (tick)
          begin
            scl_lo_d = 1'b0;
            st_d = TWM_BIT_HIGH;
          end
        end
        TWM_BIT_HIGH:
        begin
          // Clock stretch: wait until SCL is seen high
          if (tick && scl_q)
          begin
            shadow_d = {shadow_q[6:0], sda_q};
            if (buf_q[7] && !sda_q)
            begin
              // Arbitration lost: stop driving
              owner_d = 1'b0;
              sda_lo_d = 1'b0;
              slv_hit_d = addr_q && (bit_q == 3'h1) &&
                          ({shadow_q[5:0], sda_q} == `TWM_OWN_ADDR);
            end
            scl_lo_d = 1'b1;
            buf_d = {buf_q[6:0], 1'b0};
            if (bit_q == 3'h0)
            begin
              // Data released in the low phase that follows
              st_d = TWM_ACK_LOW;
            end
            else
            begin
              // Next bit goes out in the low phase that follows
              bit_d = bit_q - 3'h1;
              st_d = TWM_BIT_LOW;
            end
          end
        end
        TWM_ACK_LOW:
        begin
          // Let go of data a clock after SCL falls, so the slave can answer
          sda_lo_d = 1'b0;
          if (tick)
          begin
            scl_lo_d = 1'b0;
            st_d = TWM_ACK_HIGH;
          end
        end
        TWM_ACK_HIGH:
        begin
          if (tick && scl_q)
          begin
            scl_lo_d = 1'b1;
            ctrl_d[`TWM_B_DONE] = 1'b1;
            st_d = TWM_HOLD;
            if (!owner_q)
            begin
              // Lost: slave hand-off or 38
              if (slv_hit_q)
              begin
                code_d = shadow_q[0] ? code_of(`TWM_ST_SL_R) : code_of(`TWM_ST_SL_W);
                scl_lo_d = 1'b0;
              end
              else
                code_d = code_of(`TWM_ST_ARB);
            end
            else if (addr_q && shadow_q[0])
              // Read address: hand off to receive mode
              code_d = sda_q ? code_of(`TWM_ST_AR_NACK) : code_of(`TWM_ST_AR_ACK);
            else if (addr_q)
              code_d = sda_q ? code_of(`TWM_ST_AW_NACK) : code_of(`TWM_ST_AW_ACK);
            else
              code_d = sda_q ? code_of(`TWM_ST_D_NACK) : code_of(`TWM_ST_D_ACK);
            addr_d = 1'b0;
          end
        end
        TWM_STOP_A:
        begin
          if (tick)
          begin
            scl_lo_d = 1'b0;
            st_d = TWM_STOP_B;
          end
        end
        TWM_STOP_B:
        begin
          if (tick && scl_q)
          begin
            sda_lo_d = 1'b0;
            owner_d = 1'b0;
            ctrl_d[`TWM_B_STOP] = 1'b0;
            code_d = code_of(`TWM_ST_IDLE);
            st_d = restart_q ? TWM_WAIT_FREE : TWM_IDLE;
            restart_d = 1'b0;
          end
        end
        TWM_STOP_C:
        begin
          // SDA high, release SCL, then START again
          if (tick)
          begin
            scl_lo_d = 1'b0;
            restart_d = 1'b0;
            st_d = TWM_WAIT_FREE;
          end
        end
        default:
          st_d = TWM_IDLE;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      st_q <= TWM_IDLE;
      ctrl_q <= 8'h00;
      code_q <= code_of(`TWM_ST_IDLE);
      buf_q <= 8'hFF;
      rate_q <= `TWM_BITRATE_RST;
      tmr_q <= 8'h00;
      bit_q <= 3'h0;
      addr_q <= 1'b0;
      owner_q <= 1'b0;
      busy_q <= 1'b0;
      restart_q <= 1'b0;
      sda_lo_q <= 1'b0;
      scl_lo_q <= 1'b0;
      rdata_q <= 8'h00;
      slv_hit_q <= 1'b0;
      shadow_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      code_q <= code_d;
      buf_q <= buf_d;
      rate_q <= rate_d;
      tmr_q <= tmr_d;
      bit_q <= bit_d;
      addr_q <= addr_d;
      owner_q <= owner_d;
      busy_q <= busy_d;
      restart_q <= restart_d;
      sda_lo_q <= sda_lo_d;
      scl_lo_q <= scl_lo_d;
      rdata_q <= rdata_d;
      slv_hit_q <= slv_hit_d;
      shadow_q <= shadow_d;
    end
  end

  // Outputs straight from flip-flops; pin data outputs tied low
  assign O_RDATA = rdata_q;
  assign O_SCL = 1'b0;
  assign O_SDA = 1'b0;
  assign O_SCL_OE = scl_lo_q;
  assign O_SDA_OE = sda_lo_q;
  assign O_DONE = ctrl_q[`TWM_B_DONE];
endmodule

// >>> twm_master_bench.sv
// Purpose: self-checking bench for the two-wire master
// Assumes: slave at 0x50, rival master driven here
// Notes: half-bit of 8 clocks gives a 160 ns bus clock
`timescale 1ns/10ps
`include "twm_defines.svh"
module twm_master_bench;
  logic clk, rst, wr_s, rd_s, rival; // Clock, strobes, rival pull
  logic [1:0] addr;
  logic [7:0] wdata, rdata, v; // v holds last read
  logic scl_oe, sda_oe, slv_oe, done;
  int miscompares, cmp_count;
  // Wired-AND lines with pull-ups
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe || slv_oe || rival);
  twm_master i_dut
  (
    .I_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
    .O_RDATA(rdata), .I_SCL(scl), .I_SDA(sda), .O_SCL(), .O_SCL_OE(scl_oe), .O_SDA(),
    .O_SDA_OE(sda_oe), .O_DONE(done)
  );
  twm_slave_model i_slave (.i_scl(scl), .i_sda(sda), .o_sda_oe(slv_oe));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Gap cycle after each write keeps strobe edges apart
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  task automatic ctl(input logic [7:0] m, input logic [7:0] exp);
    rd(`TWM_ADDR_CTRL);
    chk(v & m, exp);
  endtask
  task automatic code(input logic [7:0] exp);
    rd(`TWM_ADDR_STATE);
    chk(v & 8'hF8, exp);
  endtask
  // Two negedges first, so a lagging clear is not mistaken for done
  task automatic wait_done();
    int n = 0;
    repeat (2) @(negedge clk);
    while (done !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000)
    begin
      miscompares++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] exp);
    wr(`TWM_ADDR_CTRL, c);
    wait_done();
    code(exp);
  endtask
  task automatic send(input logic [7:0] d, input logic [7:0] exp);
    wr(`TWM_ADDR_BUF, d);
    step(8'h84, exp);
  endtask
  // Bounded poll for a code reached without job-done
  task automatic poll(input logic [7:0] exp);
    int n = 0;
    do
    begin
      rd(`TWM_ADDR_STATE);
      n++;
    end
    while ((v & 8'hF8) !== exp && n < 300);
    code(exp);
    if (n >= 300)
      tally_and_finish();
  endtask
  // ****************************************
  // Clock and sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rst <= 1'b1;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    rival <= 1'b0;
    addr <= 2'h0;
    wdata <= 8'h00;
    miscompares = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    code(8'hF8);
    ctl(8'hFF, 8'h00);
    wr(`TWM_ADDR_BITRATE, 8'h07);
    // Start asked while disabled must not run
    wr(`TWM_ADDR_CTRL, 8'hA0);
    repeat (300) @(posedge clk);
    ctl(8'h80, 8'h00);
    step(8'hA4, 8'h08);
    send(8'hA0, 8'h18);
    wr(`TWM_ADDR_BUF, 8'h3C);
    wr(`TWM_ADDR_CTRL, 8'h84);
    // Buffer write in mid-byte is refused
    wr(`TWM_ADDR_BUF, 8'hFF);
    ctl(8'h88, 8'h08);
    wait_done();
    code(8'h28);
    wr(`TWM_ADDR_BUF, 8'hFF);
    ctl(8'h88, 8'h80);
    step(8'h84, 8'h30);
    step(8'hA4, 8'h10);
    send(8'hA2, 8'h20);
    step(8'hB4, 8'h08);
    ctl(8'h10, 8'h00);
    send(8'hA0, 8'h18);
    wr(`TWM_ADDR_CTRL, 8'h94);
    poll(8'hF8);
    ctl(8'h90, 8'h00);
    step(8'hA4, 8'h08);
    // Rival master holds data low through the address
    rival <= 1'b1;
    send(8'hA0, 8'h38);
    wr(`TWM_ADDR_CTRL, 8'h84);
    poll(8'hF8);
    repeat (40) @(posedge clk);
    rival <= 1'b0;
    step(8'hA4, 8'h08);
    send(8'hA1, 8'h40);
    wr(`TWM_ADDR_CTRL, 8'h80);
    poll(8'hF8);
    tally_and_finish();
  end
endmodule

// >>> twm_master_chk.sv
// Purpose: port checker for the two-wire master block
// Assumes: one clock domain, synchronous reset
// Notes: attached by the bind at the foot of this file
`timescale 1ns/10ps
module twm_master_chk
(
  // Clock, reset and register port
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic [1:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  // Bus wires and status
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SCL_OE,
  input wire logic O_SDA_OE,
  input wire logic O_DONE
);
  // ****************************************
  // Helpers
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  // Software clear of job-done
  wire logic clr = I_WR && (I_ADDR == 2'h0) && I_WDATA[7];
  // State-code read
  wire logic rd_st = I_RD && (I_ADDR == 2'h1);
  // ****************************************
  // Assertions
  // ****************************************
  AST_DONE_CLR: assert property (O_DONE && clr |-> ##[1:2] !O_DONE)
    else $error("job-done not cleared by write");
  AST_OFF_RELEASE: assert property (I_WR && I_ADDR == 2'h0 && !I_WDATA[2] |-> ##[1:3] (!O_SCL_OE && !O_SDA_OE))
    else $error("bus not released when disabled");
  AST_START_FREE: assert property ($rose(O_SDA_OE) && !O_SCL_OE && I_SCL |-> $past(I_SDA))
    else $error("start issued on a busy bus");
  AST_CODE_SET: assert property ($past(rd_st) && $past(O_DONE) |-> O_RDATA inside {8'h08, 8'h10, 8'h18, 8'h20,
    8'h28, 8'h30, 8'h38, 8'h40, 8'h48, 8'h68, 8'h78, 8'hB0})
    else $error("undocumented state code with job-done");
  AST_CODE_MASK: assert property ($past(rd_st) |-> O_RDATA[2:0] == 3'h0)
    else $error("prescaler field not zero");
  AST_WCOL_SET: assert property ((I_WR && I_ADDR == 2'h2 && !O_DONE) ##2 (I_RD && I_ADDR == 2'h0) |=> O_RDATA[3])
    else $error("collision flag not set");
  AST_WCOL_CLR: assert property ((I_WR && I_ADDR == 2'h2 && O_DONE) ##2 (I_RD && I_ADDR == 2'h0) |=> !O_RDATA[3])
    else $error("collision flag not cleared");
  AST_DONE_HOLD: assert property (O_DONE && !clr && !$past(clr) |=> O_DONE)
    else $error("job-done dropped without software");
  AST_BUS_FROZEN: assert property (O_DONE && $past(O_DONE) && !$past(clr) |-> $stable(O_SCL_OE) && $stable(O_SDA_OE))
    else $error("bus moved while suspended");
endmodule
bind twm_master twm_master_chk i_chk
(
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
  .O_RDATA(O_RDATA), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SCL_OE(O_SCL_OE), .O_SDA_OE(O_SDA_OE), .O_DONE(O_DONE)
);

// >>> twm_pkg.sv
// Purpose: types for the two-wire master-transmitter block
// Assumes: nothing
// Notes: constants live in twm_defines.svh
package twm_pkg;
  // Bus sequencer states
  typedef enum logic [3:0]
  {
    TWM_IDLE,
    TWM_WAIT_FREE,
    TWM_START_A,
    TWM_START_B,
    TWM_BIT_LOW,
    TWM_BIT_HIGH,
    TWM_ACK_LOW,
    TWM_ACK_HIGH,
    TWM_HOLD,
    TWM_STOP_A,
    TWM_STOP_B,
    TWM_STOP_C
  } twm_state_t;
endpackage

// >>> twm_slave_model.sv
// Purpose: slave receiver on the two-wire bus
// Assumes: lines pulled up, master drives the clock
// Notes: acks its address and every data byte but 0xFF
`timescale 1ns/10ps
module twm_slave_model
#(
  // Address this slave answers to
  parameter logic [6:0] SLV_ADDR = 7'h50
)
(
  // Bus wires
  input wire logic i_scl,
  input wire logic i_sda,
  // High pulls data low
  output logic o_sda_oe
);
  int bit_cnt; // Bits of this byte
  logic [7:0] shift_q; // Byte being collected
  logic addr_phase; // First byte after a start
  initial
  begin
    o_sda_oe = 1'b0;
    bit_cnt = 0;
    addr_phase = 1'b0;
  end
  // Start: data falls while clock high
  always @(negedge i_sda)
  begin
    if (i_scl)
    begin
      bit_cnt = 0;
      addr_phase = 1'b1;
    end
  end
  // Sample on clock rise, MSB first
  always @(posedge i_scl)
  begin
    shift_q = {shift_q[6:0], i_sda};
    bit_cnt = bit_cnt + 1;
  end
  // Ack after the 8th bit; release after the 9th so the line floats high
  always @(negedge i_scl)
  begin
    if (bit_cnt == 8)
      o_sda_oe <= addr_phase ? (shift_q[7:1] == SLV_ADDR) : (shift_q != 8'hFF);
    else if (bit_cnt == 9)
    begin
      o_sda_oe <= 1'b0;
      bit_cnt = 0;
      addr_phase = 1'b0;
    end
  end
endmodule
